// ### logic/hpsc_host_port_ctrl.sv
// Host port switch control bank: Avalon-MM register slave plus frame gates.
// Assumes a synchronous bus master on clk and frame descriptors from the switch core.
//
// Functional notes
// - Ingress filter set: drop host frames whose VLAN membership lacks the host port.
// - Non-default VID discard set: drop host frames whose VID differs from default.
// - Transmit enable, set at reset; clear blocks all host port transmission.
// - Receive enable, set at reset; clear blocks all host port reception.
// - Learning disable set stops source address learning; clear at reset.
// - Sniffer bit makes host port transmit every monitored frame.
// - Receive mirror: received frames tagged monitored and copied to sniffer port.
// - Transmit mirror: transmitted frames tagged monitored and copied to sniffer port.
// - Priority ceiling: priority above default tag priority replaced by it.
// - Three-bit membership mask, reset all ones: host, port two, port one.
// - Host frames go only to ports inside the membership mask.
// - Control one, VID, control three and rate registers behave as port one's.
// - Banks above host bank reserved, bank select still reachable in them.
// - Control two bits 15, 12, 11 and 4 read as zero.
module hpsc_host_port_ctrl (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic [5:0]  avs_address,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [11:0] rx_vid,
    input  wire logic [2:0]  rx_pri,
    input  wire logic [2:0]  rx_vlan_member,
    input  wire logic [2:0]  rx_dest_mask,
    input  wire logic [2:0]  sniff_mask,
    input  wire logic        tx_valid,
    input  wire logic        tx_dest_host,
    input  wire logic        tx_monitored,
    output logic             fwd_valid,
    output logic             fwd_drop,
    output logic [2:0]       fwd_mask,
    output logic             fwd_learn,
    output logic             fwd_monitored,
    output logic [2:0]       fwd_pri,
    output logic             tx_send,
    output logic             tx_tag_monitored,
    output logic [2:0]       tx_mirror_mask,
    output logic [15:0]      cfg_ctrl_one,
    output logic [15:0]      cfg_vlan_id,
    output logic [15:0]      cfg_ctrl_three,
    output logic [15:0]      cfg_ingress_rate,
    output logic [15:0]      cfg_egress_rate
);

    // ------------------------------------------------------------
    // Register map tables
    // ------------------------------------------------------------
    // Slot order follows the printed index order of the host bank.
    localparam logic [5:0] REG_IDX [hpsc_pkg::NREG] = '{
        hpsc_pkg::IDX_CTRL1, hpsc_pkg::IDX_CTRL2, hpsc_pkg::IDX_VIDCR,
        hpsc_pkg::IDX_CTRL3, hpsc_pkg::IDX_IRATE, hpsc_pkg::IDX_ERATE};

    typedef struct packed {
        logic                              waiting;
        logic [31:0]                       rdata;
        logic [15:0]                       bank;
        logic [hpsc_pkg::NREG-1:0][15:0]   regs;
        logic [15:0]                       c1;
        logic [15:0]                       vid;
        logic [15:0]                       c3;
        logic [15:0]                       irate;
        logic [15:0]                       erate;
    } hpsc_state_t;

    hpsc_state_t st;
    hpsc_state_t next_st;

    logic        req;
    logic        accept;
    logic        host_sel;
    logic        bank_hit;
    logic        hit;
    logic [15:0] rd_word;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte lanes two and three carry nothing; only the low half is stored.
    function automatic logic [15:0] hpsc_merge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be,
        input logic [15:0] msk
    );
        logic [15:0] lane;
        lane = {{8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~lane) | (wd[15:0] & lane);
    endfunction

    function automatic logic [5:0] hpsc_byte_addr(input logic [5:0] idx);
        return {idx[3:0], 2'b00};
    endfunction

    function automatic logic [15:0] hpsc_rw_mask(input int unsigned slot);
        return (slot == hpsc_pkg::SLOT_CTRL2) ? hpsc_pkg::CTRL2_RW : hpsc_pkg::FULL_RW;
    endfunction

    function automatic logic [15:0] hpsc_rst(input int unsigned slot);
        return (slot == hpsc_pkg::SLOT_CTRL2) ? hpsc_pkg::CTRL2_RST : hpsc_pkg::OTHER_RST;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // The bank select word decodes in every bank, so software is never
    // locked out after selecting a reserved bank.
    always_comb begin
        req = avs_read || avs_write;
        accept = req && !st.waiting;
        bank_hit = (avs_address == hpsc_byte_addr(hpsc_pkg::IDX_BANK));
        host_sel = (st.bank[5:0] == hpsc_pkg::HOST_BANK);
        hit = bank_hit;
        rd_word = bank_hit ? st.bank : 16'h0000;
        // host bank registers, other banks read zero
        for (int unsigned i = 0; i < hpsc_pkg::NREG; i++) begin
            if (host_sel && avs_address == hpsc_byte_addr(REG_IDX[i])) begin
                hit = 1'b1;
                rd_word = st.regs[i] & hpsc_rw_mask(i);
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Waitrequest drops for exactly one cycle per request; the write lands
    // on the edge at which the master sees it low.
    always_comb begin
        next_st = st;
        next_st.waiting = !(req && st.waiting);
        if (req && st.waiting) begin
            next_st.rdata = {16'h0000, rd_word};
        end
        if (accept && avs_write && bank_hit) begin
            next_st.bank = hpsc_merge(st.bank, avs_writedata, avs_byteenable,
                                      hpsc_pkg::BANK_MASK);
        end
        // writes outside the host bank ignored
        for (int unsigned i = 0; i < hpsc_pkg::NREG; i++) begin
            if (accept && avs_write && host_sel
                && avs_address == hpsc_byte_addr(REG_IDX[i])) begin
                next_st.regs[i] = hpsc_merge(st.regs[i], avs_writedata,
                                             avs_byteenable, hpsc_rw_mask(i));
            end
        end
        // copies handed to the port-one style logic
        next_st.c1 = st.regs[0];
        next_st.vid = st.regs[hpsc_pkg::SLOT_VIDCR];
        next_st.c3 = st.regs[3];
        next_st.irate = st.regs[4];
        next_st.erate = st.regs[5];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // The clock enable freezes the bus handshake as well as the bank.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.waiting <= 1'b1;
            // membership resets to all ones, enables set
            for (int unsigned i = 0; i < hpsc_pkg::NREG; i++) begin
                st.regs[i] <= hpsc_rst(i);
            end
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign avs_readdata     = st.rdata;
    assign avs_waitrequest  = st.waiting;
    assign cfg_ctrl_one     = st.c1;
    assign cfg_vlan_id      = st.vid;
    assign cfg_ctrl_three   = st.c3;
    assign cfg_ingress_rate = st.irate;
    assign cfg_egress_rate  = st.erate;

    // ------------------------------------------------------------
    // Frame gates
    // ------------------------------------------------------------
    // Both gates read the live control word so a write acts on the next frame.
    hpsc_ingress u_ingress (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .ce             (ce),
        .rx_valid       (rx_valid),
        .rx_vid         (rx_vid),
        .rx_pri         (rx_pri),
        .rx_vlan_member (rx_vlan_member),
        .rx_dest_mask   (rx_dest_mask),
        .sniff_mask     (sniff_mask),
        .ctrl           (st.regs[hpsc_pkg::SLOT_CTRL2]),
        .def_tag        (st.regs[hpsc_pkg::SLOT_VIDCR]),
        .fwd_valid      (fwd_valid),
        .fwd_drop       (fwd_drop),
        .fwd_mask       (fwd_mask),
        .fwd_learn      (fwd_learn),
        .fwd_monitored  (fwd_monitored),
        .fwd_pri        (fwd_pri)
    );

    hpsc_egress u_egress (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .ce               (ce),
        .tx_valid         (tx_valid),
        .tx_dest_host     (tx_dest_host),
        .tx_monitored     (tx_monitored),
        .sniff_mask       (sniff_mask),
        .ctrl             (st.regs[hpsc_pkg::SLOT_CTRL2]),
        .tx_send          (tx_send),
        .tx_tag_monitored (tx_tag_monitored),
        .tx_mirror_mask   (tx_mirror_mask)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_req_seen;
        ce && req && avs_waitrequest;
    endsequence

    sequence s_wr_accept;
        ce && avs_write && !avs_waitrequest;
    endsequence

    AST_WAIT_ONE: assert property (@(posedge clk) disable iff (sys_rst)
        s_req_seen |=> !avs_waitrequest)
        else $error("Waitrequest did not drop one cycle after request.");
    AST_CTRL2_RSVD: assert property (@(posedge clk) disable iff (sys_rst)
        (st.regs[hpsc_pkg::SLOT_CTRL2] & ~hpsc_pkg::CTRL2_RW) == 16'h0000)
        else $error("Reserved control two bit became set.");
    AST_RSVD_BANK_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (s_wr_accept and (!host_sel && !bank_hit)) |=> $stable(st.regs))
        else $error("Write outside host bank changed a register.");
    AST_BANK_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (s_wr_accept and (bank_hit && avs_byteenable[0]))
        |=> st.bank[5:0] == $past(avs_writedata[5:0]))
        else $error("Bank select write not taken.");
    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        (avs_read && !avs_waitrequest && !hit) |-> avs_readdata == 32'h00000000)
        else $error("Unmapped read returned nonzero data.");
    AST_MEMB_RESET: assert property (@(posedge clk)
        $fell(sys_rst) |-> st.regs[hpsc_pkg::SLOT_CTRL2][hpsc_pkg::MEMB_MSB:0] == 3'h7)
        else $error("Membership mask not all ones after reset.");
endmodule

// ### shared/hpsc_pkg.sv
// Constants for the host port switch control register bank.
// Assumes a 32-bit word bus; each 16-bit register sits in the low half of one word.
package hpsc_pkg;

    // ------------------------------------------------------------
    // Register indices, bank numbers and bus widths
    // ------------------------------------------------------------
    localparam int unsigned NREG       = 6;
    localparam int unsigned AW         = 6;
    localparam logic [5:0]  IDX_CTRL1  = 6'h00;
    localparam logic [5:0]  IDX_CTRL2  = 6'h02;
    localparam logic [5:0]  IDX_VIDCR  = 6'h04;
    localparam logic [5:0]  IDX_CTRL3  = 6'h06;
    localparam logic [5:0]  IDX_IRATE  = 6'h08;
    localparam logic [5:0]  IDX_ERATE  = 6'h0a;
    localparam logic [5:0]  IDX_BANK   = 6'h0e;
    localparam logic [5:0]  HOST_BANK  = 6'h34;
    localparam logic [15:0] BANK_MASK  = 16'h003f;
    localparam int unsigned SLOT_CTRL2 = 1;
    localparam int unsigned SLOT_VIDCR = 2;

    // ------------------------------------------------------------
    // Control register two field layout and reset
    // ------------------------------------------------------------
    localparam int unsigned B_INGF   = 14;
    localparam int unsigned B_NPVID  = 13;
    localparam int unsigned B_TXEN   = 10;
    localparam int unsigned B_RXEN   = 9;
    localparam int unsigned B_LRNDIS = 8;
    localparam int unsigned B_SNIFP  = 7;
    localparam int unsigned B_RXSNF  = 6;
    localparam int unsigned B_TXSNF  = 5;
    localparam int unsigned B_PCEIL  = 3;
    localparam int unsigned MEMB_MSB = 2;
    localparam logic [15:0] CTRL2_RW  = 16'h67ef;
    localparam logic [15:0] CTRL2_RST = 16'h0607;
    localparam logic [15:0] OTHER_RST = 16'h0000;
    localparam logic [15:0] FULL_RW   = 16'hffff;

    // ------------------------------------------------------------
    // Default tag layout and port numbering
    // ------------------------------------------------------------
    localparam int unsigned VID_MSB = 11;
    localparam int unsigned PRI_MSB = 15;
    localparam int unsigned PRI_LSB = 13;
    localparam int unsigned P_HOST  = 2;
    localparam logic [2:0]  HOST_BIT = 3'h4;
endpackage

// ### logic/hpsc_ingress.sv
// Per-frame ingress decision for frames received on the host port.
// Assumes one frame descriptor per rx_valid pulse, synchronous to clk.
module hpsc_ingress (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        rx_valid,
    input  wire logic [11:0] rx_vid,
    input  wire logic [2:0]  rx_pri,
    input  wire logic [2:0]  rx_vlan_member,
    input  wire logic [2:0]  rx_dest_mask,
    input  wire logic [2:0]  sniff_mask,
    input  wire logic [15:0] ctrl,
    input  wire logic [15:0] def_tag,
    output logic             fwd_valid,
    output logic             fwd_drop,
    output logic [2:0]       fwd_mask,
    output logic             fwd_learn,
    output logic             fwd_monitored,
    output logic [2:0]       fwd_pri
);
    typedef struct packed {
        logic       valid;
        logic       drop;
        logic [2:0] mask;
        logic       learn;
        logic       mon;
        logic [2:0] pri;
    } hpsc_ing_t;

    hpsc_ing_t st;
    hpsc_ing_t next_st;
    logic      drop_c;
    logic [2:0] memb;
    logic [2:0] dpri;

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    // Drop reasons are ORed; a dropped frame is neither learned nor forwarded.
    always_comb begin
        memb = ctrl[hpsc_pkg::MEMB_MSB:0];
        dpri = def_tag[hpsc_pkg::PRI_MSB:hpsc_pkg::PRI_LSB];
        drop_c = !ctrl[hpsc_pkg::B_RXEN];
        if (ctrl[hpsc_pkg::B_INGF] && !rx_vlan_member[hpsc_pkg::P_HOST]) begin
            drop_c = 1'b1;
        end
        if (ctrl[hpsc_pkg::B_NPVID] && rx_vid != def_tag[hpsc_pkg::VID_MSB:0]) begin
            drop_c = 1'b1;
        end
        next_st = st;
        next_st.valid = rx_valid;
        next_st.drop = rx_valid && drop_c;
        next_st.mask = (rx_dest_mask | (ctrl[hpsc_pkg::B_RXSNF] ? sniff_mask : 3'h0))
                       & memb & ~hpsc_pkg::HOST_BIT;
        if (!rx_valid || drop_c) begin
            next_st.mask = 3'h0;
        end
        next_st.learn = rx_valid && !drop_c && !ctrl[hpsc_pkg::B_LRNDIS];
        next_st.mon = rx_valid && !drop_c && ctrl[hpsc_pkg::B_RXSNF];
        next_st.pri = (ctrl[hpsc_pkg::B_PCEIL] && rx_pri > dpri) ? dpri : rx_pri;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign fwd_valid     = st.valid;
    assign fwd_drop      = st.drop;
    assign fwd_mask      = st.mask;
    assign fwd_learn     = st.learn;
    assign fwd_monitored = st.mon;
    assign fwd_pri       = st.pri;

    AST_RXEN_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && rx_valid && !ctrl[hpsc_pkg::B_RXEN]) |=> (fwd_drop && fwd_mask == 3'h0))
        else $error("Frame accepted with reception disabled.");
    AST_INGF_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && rx_valid && ctrl[hpsc_pkg::B_INGF] && !rx_vlan_member[hpsc_pkg::P_HOST])
        |=> (fwd_drop && !fwd_learn))
        else $error("Non-member frame passed ingress filter.");
    AST_PCEIL: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && ctrl[hpsc_pkg::B_PCEIL] && rx_pri > dpri) |=> (fwd_pri == $past(dpri)))
        else $error("Priority above ceiling not replaced.");
endmodule

// ### logic/hpsc_egress.sv
// Transmit gate for frames offered to the host port.
// Assumes one offered frame per tx_valid pulse, synchronous to clk.
module hpsc_egress (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        tx_valid,
    input  wire logic        tx_dest_host,
    input  wire logic        tx_monitored,
    input  wire logic [2:0]  sniff_mask,
    input  wire logic [15:0] ctrl,
    output logic             tx_send,
    output logic             tx_tag_monitored,
    output logic [2:0]       tx_mirror_mask
);
    typedef struct packed {
        logic       send;
        logic       tag;
        logic [2:0] mmask;
    } hpsc_egr_t;

    hpsc_egr_t st;
    hpsc_egr_t next_st;
    logic      go;

    // ------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------
    // A sniffer port also carries frames that are only monitored copies.
    always_comb begin
        go = tx_valid && ctrl[hpsc_pkg::B_TXEN]
             && (tx_dest_host || (ctrl[hpsc_pkg::B_SNIFP] && tx_monitored));
        next_st = st;
        next_st.send = go;
        next_st.tag = go && ctrl[hpsc_pkg::B_TXSNF];
        next_st.mmask = next_st.tag ? (sniff_mask & ctrl[hpsc_pkg::MEMB_MSB:0]
                                       & ~hpsc_pkg::HOST_BIT) : 3'h0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign tx_send          = st.send;
    assign tx_tag_monitored = st.tag;
    assign tx_mirror_mask   = st.mmask;

    AST_TXEN_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && !ctrl[hpsc_pkg::B_TXEN]) |=> !tx_send)
        else $error("Frame sent with transmission disabled.");
endmodule

// ### testbench/hpsc_host_port_ctrl_tb_top.sv
// Self-checking bench for the host port switch control bank.
// Assumes the package and design sources are compiled first; the bench drives every port itself.
module hpsc_host_port_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Table layout and signals
    // ------------------------------------------------------------
    typedef struct {
        logic [15:0] ctrl;
        logic [11:0] vid;
        logic [2:0]  pri, mem, dst, snf;
        logic        dh, mon, e_drop;
        logic [2:0]  e_mask;
        logic        e_lrn, e_mon;
        logic [2:0]  e_pri;
        logic        e_send, e_tag;
        logic [2:0]  e_mm;
    } hpsc_row_t;

    logic        clk = 1'h0, sys_rst = 1'h1, ce = 1'h1;
    logic [5:0]  avs_address = 6'h00;
    logic [3:0]  avs_byteenable = 4'h0;
    logic        avs_read = 1'h0, avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, rx_valid = 1'h0, tx_valid = 1'h0;
    logic        tx_dest_host = 1'h0, tx_monitored = 1'h0;
    logic [11:0] rx_vid = 12'h000;
    logic [2:0]  rx_pri = 3'h0, rx_vlan_member = 3'h0, rx_dest_mask = 3'h0, sniff_mask = 3'h0;
    logic        fwd_valid, fwd_drop, fwd_learn, fwd_monitored, tx_send, tx_tag_monitored;
    logic [2:0]  fwd_mask, fwd_pri, tx_mirror_mask;
    logic [15:0] cfg_ctrl_one, cfg_vlan_id, cfg_ctrl_three, cfg_ingress_rate, cfg_egress_rate;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    logic [5:0]  cfg_addr [4] = '{6'h00, 6'h18, 6'h20, 6'h28};
    logic [15:0] cfg_val [4] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081};
    logic [15:0] rsv_bank [2] = '{16'h0035, 16'h003f};

    // Ordinary cases; default tag is VID 0x123 with priority 3.
    // Columns: control two, VID, priority, member, dest, sniffer, tx dest, tx monitored,
    // then drop, mask, learn, monitored, priority, send, tx tag, tx mirror mask.
    hpsc_row_t rows [16] = '{
        '{16'h0607, 12'h123, 3'h5, 3'h0, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h4607, 12'h123, 3'h5, 3'h3, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h1, 3'h0, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h4607, 12'h123, 3'h5, 3'h4, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h2607, 12'h124, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h1, 3'h0, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h2607, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h0407, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h1, 3'h0, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h0207, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h5, 1'h0, 1'h0, 3'h0},
        '{16'h0707, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h0647, 12'h123, 3'h5, 3'h7, 3'h1, 3'h2, 1'h0, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h1, 3'h5, 1'h0, 1'h0, 3'h0},
        '{16'h0687, 12'h123, 3'h5, 3'h7, 3'h0, 3'h0, 1'h0, 1'h1,
          1'h0, 3'h0, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h0607, 12'h123, 3'h5, 3'h7, 3'h0, 3'h0, 1'h0, 1'h1,
          1'h0, 3'h0, 1'h1, 1'h0, 3'h5, 1'h0, 1'h0, 3'h0},
        '{16'h0627, 12'h123, 3'h5, 3'h7, 3'h1, 3'h2, 1'h1, 1'h0,
          1'h0, 3'h1, 1'h1, 1'h0, 3'h5, 1'h1, 1'h1, 3'h2},
        '{16'h060f, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h3, 1'h1, 1'h0, 3'h0},
        '{16'h060f, 12'h123, 3'h2, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h3, 1'h1, 1'h0, 3'h2, 1'h1, 1'h0, 3'h0},
        '{16'h0605, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h1, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0},
        '{16'h0600, 12'h123, 3'h5, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0,
          1'h0, 3'h0, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h0}
    };

    hpsc_host_port_ctrl u_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
        .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_vid(rx_vid),
        .rx_pri(rx_pri), .rx_vlan_member(rx_vlan_member), .rx_dest_mask(rx_dest_mask),
        .sniff_mask(sniff_mask), .tx_valid(tx_valid), .tx_dest_host(tx_dest_host),
        .tx_monitored(tx_monitored), .fwd_valid(fwd_valid), .fwd_drop(fwd_drop),
        .fwd_mask(fwd_mask), .fwd_learn(fwd_learn), .fwd_monitored(fwd_monitored),
        .fwd_pri(fwd_pri), .tx_send(tx_send), .tx_tag_monitored(tx_tag_monitored),
        .tx_mirror_mask(tx_mirror_mask), .cfg_ctrl_one(cfg_ctrl_one),
        .cfg_vlan_id(cfg_vlan_id), .cfg_ctrl_three(cfg_ctrl_three),
        .cfg_ingress_rate(cfg_ingress_rate), .cfg_egress_rate(cfg_egress_rate)
    );

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    // The 5 ns clock; the ceiling is far above the few hundred cycles the tests need.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; the request is held until waitrequest is sampled low at an edge.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        {avs_read, avs_write} <= {~wr, wr};
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        bus(1'h0, a, 16'h0000, 4'h3);
        check(q, {16'h0000, exp});
    endtask

    // One receive and one transmit descriptor together; results show one cycle later.
    task automatic frame(input hpsc_row_t r);
        @(posedge clk);
        {rx_valid, rx_vid, rx_pri, rx_vlan_member} <= {1'h1, r.vid, r.pri, r.mem};
        {rx_dest_mask, sniff_mask} <= {r.dst, r.snf};
        {tx_valid, tx_dest_host, tx_monitored} <= {1'h1, r.dh, r.mon};
        @(posedge clk);
        {rx_valid, tx_valid} <= 2'h0;
        #1;
        check({27'h0, fwd_valid, fwd_drop, fwd_mask},
              {27'h0, 1'h1, r.e_drop, r.e_mask});
        check({27'h0, fwd_learn, fwd_monitored, fwd_pri},
              {27'h0, r.e_lrn, r.e_mon, r.e_pri});
        check({27'h0, tx_send, tx_tag_monitored, tx_mirror_mask},
              {27'h0, r.e_send, r.e_tag, r.e_mm});
    endtask

    task automatic report_and_stop;
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        rd(6'h38, 16'h0000);
        bus(1'h1, 6'h38, 16'h0034, 4'h3);
        rd(6'h08, 16'h0607);
        bus(1'h1, 6'h10, 16'h6123, 4'h3);
        foreach (rows[i]) begin
            bus(1'h1, 6'h08, rows[i].ctrl, 4'h3);
            rd(6'h08, rows[i].ctrl & hpsc_pkg::CTRL2_RW);
            frame(rows[i]);
        end
        $display("Test table: %0d rows done", $size(rows));
        // Plain registers read back what was written and appear on the copies.
        foreach (cfg_addr[i]) begin
            bus(1'h1, cfg_addr[i], cfg_val[i], 4'h3);
            rd(cfg_addr[i], cfg_val[i]);
        end
        bus(1'h1, 6'h00, 16'hffff, 4'h1);
        rd(6'h00, 16'h1aff);
        check({cfg_ctrl_one, cfg_vlan_id}, {16'h1aff, 16'h6123});
        check({cfg_ctrl_three, cfg_ingress_rate}, {16'h3c4d, 16'h5e6f});
        check({16'h0000, cfg_egress_rate}, {16'h0000, 16'h7081});
        $display("Test plain registers: done");
        // Reserved bits, a hole in the host bank, and reserved banks above it.
        bus(1'h1, 6'h08, 16'hffff, 4'h3);
        rd(6'h08, 16'h67ef);
        bus(1'h1, 6'h30, 16'hffff, 4'h3);
        rd(6'h30, 16'h0000);
        foreach (rsv_bank[i]) begin
            bus(1'h1, 6'h38, rsv_bank[i], 4'h3);
            rd(6'h38, rsv_bank[i]);
            bus(1'h1, 6'h08, 16'h0000, 4'h3);
            rd(6'h08, 16'h0000);
        end
        bus(1'h1, 6'h38, 16'h0034, 4'h3);
        rd(6'h08, 16'h67ef);
        $display("Test reserved space: done");
        // A second reset in mid-run restores the bank select, control one, egress rate and control two defaults.
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        rd(6'h38, 16'h0000);
        check({cfg_ctrl_one, cfg_egress_rate}, 32'h0);
        bus(1'h1, 6'h38, 16'h0034, 4'h3);
        rd(6'h08, 16'h0607);
        $display("Test second reset: done");
        report_and_stop();
    end
endmodule
